/* hdl/cwx_defs.svh */
// Constants for the word, multiply, OR and dispatch execution unit.
`ifndef CWX_DEFS_SVH
`define CWX_DEFS_SVH
// ==========================================================================
// APB register byte offsets
`define CWX_OFS_CMD    8'h00
`define CWX_OFS_STATUS 8'h04
`define CWX_OFS_FLAGS  8'h08
`define CWX_OFS_PC     8'h0C
`define CWX_OFS_IP     8'h10
`define CWX_OFS_RFADDR 8'h14
`define CWX_OFS_RFDATA 8'h18
// ==========================================================================
// Status and flag bit positions
`define CWX_ST_BUSY 0
`define CWX_ST_ERR  1
`define CWX_FLAG_C  7
`define CWX_FLAG_Z  6
`define CWX_FLAG_S  5
`define CWX_FLAG_V  4
`define CWX_FLAG_D  3
`define CWX_FLAG_H  2
// ==========================================================================
// Reset values and addressing
`define CWX_FLAGS_RST 8'h00
`define CWX_PC_RST    16'h0000
`define CWX_IP_RST    16'h0000
`define CWX_WORK_HI   4'hC
`define CWX_IP_STEP   16'h0002
// ==========================================================================
// Opcodes
`define CWX_OP_OR_W   8'h42
`define CWX_OP_OR_WI  8'h43
`define CWX_OP_OR_R   8'h44
`define CWX_OP_OR_IR  8'h45
`define CWX_OP_OR_IM  8'h46
`define CWX_OP_MUL_R  8'h84
`define CWX_OP_MUL_IR 8'h85
`define CWX_OP_MUL_IM 8'h86
`define CWX_OP_LDW_RR 8'hC4
`define CWX_OP_LDW_IR 8'hC5
`define CWX_OP_LDW_IM 8'hC6
`define CWX_OP_NEXT   8'h0F
`define CWX_OP_NOP    8'hFF
// ==========================================================================
// Execution times in cycles
`define CWX_CYC_LDW  5'h08
`define CWX_CYC_MUL  5'h16
`define CWX_CYC_NEXT 5'h0A
`define CWX_CYC_NOP  5'h04
`define CWX_CYC_ORW  5'h04
`define CWX_CYC_OR   5'h06
`endif

/* hdl/cwx_pkg.sv */
// Types shared by the execution unit modules.
package cwx_pkg;
    typedef enum logic [1:0] {
        CWX_IDLE,
        CWX_RUN,
        CWX_FETCH,
        CWX_HOLD
    } cwx_state_t;
endpackage : cwx_pkg

/* hdl/cwx_ctl_if.sv */
// Control carrier between the APB slave and the execution core.
`timescale 1ns/1ps
interface cwx_ctl_if;
    logic [31:0] wdata;
    logic        wr_cmd;
    logic        wr_flags;
    logic        wr_pc;
    logic        wr_ip;
    logic        wr_rfaddr;
    logic        wr_rfdata;
    logic        clr_err;
    logic [31:0] cmd;
    logic        busy;
    logic        err;
    logic [7:0]  flags;
    logic [15:0] pc;
    logic [15:0] ip;
    logic [7:0]  rfaddr;
    logic [7:0]  rfdata;
    modport bus (output wdata, wr_cmd, wr_flags, wr_pc, wr_ip, wr_rfaddr,
                 wr_rfdata, clr_err,
                 input cmd, busy, err, flags, pc, ip, rfaddr, rfdata);
    modport core (input wdata, wr_cmd, wr_flags, wr_pc, wr_ip, wr_rfaddr,
                  wr_rfdata, clr_err,
                  output cmd, busy, err, flags, pc, ip, rfaddr, rfdata);
endinterface : cwx_ctl_if

/* hdl/cwx_alu.sv */
// Multiply and OR datapath with flag generation.
`timescale 1ns/1ps
`include "cwx_defs.svh"
module cwx_alu (
    input  wire logic        mul,
    input  wire logic [7:0]  a,
    input  wire logic [7:0]  b,
    input  wire logic [7:0]  fin,
    output logic      [15:0] res,
    output logic      [7:0]  fout
);
    always_comb begin
        res  = mul ? (16'(a) * 16'(b)) : {8'h00, a | b};
        fout = fin;
        fout[`CWX_FLAG_V] = 1'b0;
        if (mul) begin
            fout[`CWX_FLAG_C] = res > 16'h00FF;
            fout[`CWX_FLAG_Z] = res == 16'h0000;
            fout[`CWX_FLAG_S] = res[15];
        end else begin
            fout[`CWX_FLAG_Z] = res[7:0] == 8'h00;
            fout[`CWX_FLAG_S] = res[7];
        end
    end
endmodule : cwx_alu

/* hdl/cwx_apb.sv */
// APB slave that decodes the control registers of the execution unit.
`timescale 1ns/1ps
`include "cwx_defs.svh"
module cwx_apb (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    cwx_ctl_if.bus           ctl
);
    logic        acc;
    logic [31:0] rd_val;
    logic        hit;

    // The answer is registered so every bus output leaves a flip-flop;
    // it is prepared in the setup cycle, so transfers need no wait state.
    assign acc = ce & psel & penable & pwrite & pready;
    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == `CWX_OFS_CMD) begin
            rd_val = ctl.cmd;
        end else if (paddr == `CWX_OFS_STATUS) begin
            rd_val[`CWX_ST_BUSY] = ctl.busy;
            rd_val[`CWX_ST_ERR]  = ctl.err;
        end else if (paddr == `CWX_OFS_FLAGS) begin
            rd_val[7:0] = ctl.flags;
        end else if (paddr == `CWX_OFS_PC) begin
            rd_val[15:0] = ctl.pc;
        end else if (paddr == `CWX_OFS_IP) begin
            rd_val[15:0] = ctl.ip;
        end else if (paddr == `CWX_OFS_RFADDR) begin
            rd_val[7:0] = ctl.rfaddr;
        end else if (paddr == `CWX_OFS_RFDATA) begin
            rd_val[7:0] = ctl.rfdata;
        end else begin
            hit = 1'b0;
        end
    end

    assign ctl.wdata     = pwdata;
    assign ctl.wr_cmd    = acc & (paddr == `CWX_OFS_CMD);
    assign ctl.clr_err   = acc & (paddr == `CWX_OFS_STATUS)
                         & pwdata[`CWX_ST_ERR];
    assign ctl.wr_flags  = acc & (paddr == `CWX_OFS_FLAGS);
    assign ctl.wr_pc     = acc & (paddr == `CWX_OFS_PC);
    assign ctl.wr_ip     = acc & (paddr == `CWX_OFS_IP);
    assign ctl.wr_rfaddr = acc & (paddr == `CWX_OFS_RFADDR);
    assign ctl.wr_rfdata = acc & (paddr == `CWX_OFS_RFDATA);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel & ~penable & ~pready;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0000_0000;
            pslverr <= psel & ~penable & ~hit;
        end
    end
endmodule : cwx_apb

/* hdl/cwx_exec.sv */
// Execution unit for word load, multiply, OR, dispatch and no-operation.
// Function
// - Word load copies whole source, source kept
// - Word load opcodes C4 C5 C6, 8 cycles
// - Multiply source by even destination byte, 22 cycles
// - Product high byte even, low byte odd
// - Multiply carry set when product exceeds 255
// - Multiply zero, sign set; overflow cleared
// - Dispatch loads counter from pointed word
// - Dispatch then advances instruction pointer by two
// - No-operation changes nothing, takes 4 cycles
// - Word load, dispatch, no-operation keep flags
// - OR stores destination OR source, 42-46
// - OR keeps source; 4 or 6 cycles
// - OR zero, sign set; overflow cleared; carry kept
`timescale 1ns/1ps
`include "cwx_defs.svh"
module cwx_exec (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pm_rd,
    output logic      [15:0] pm_addr,
    input  wire logic [15:0] pm_rdata,
    input  wire logic        pm_valid
);
    cwx_ctl_if ctl ();

    logic [7:0]          rf [0:255];
    cwx_pkg::cwx_state_t state_reg;
    logic [31:0]         cmd_reg;
    logic [4:0]          cnt_reg;
    logic [4:0]          cyc_reg;
    logic [4:0]          run_len;
    logic                err_reg;
    logic [7:0]          flags_reg;
    logic [15:0]         pc_reg;
    logic [15:0]         ip_reg;
    logic [7:0]          rfaddr_reg;
    logic [7:0]          op;
    logic [7:0]          b1;
    logic [7:0]          b2;
    logic [7:0]          b3;
    logic [7:0]          sa;
    logic [7:0]          da;
    logic [7:0]          ea;
    logic [7:0]          ep;
    logic [7:0]          dp;
    logic [7:0]          src8;
    logic [15:0]         srcw;
    logic                imm;
    logic                ind;
    logic                is_or;
    logic                is_mul;
    logic                is_ldw;
    logic                run;
    logic                busy;
    logic                start;
    logic [4:0]          new_cyc;
    logic [15:0]         res;
    logic [7:0]          flags_next;

    function automatic logic [4:0] cyc_of(input logic [7:0] o);
        case (o)
            `CWX_OP_LDW_RR, `CWX_OP_LDW_IR, `CWX_OP_LDW_IM: begin
                cyc_of = `CWX_CYC_LDW;
            end
            `CWX_OP_MUL_R, `CWX_OP_MUL_IR, `CWX_OP_MUL_IM: begin
                cyc_of = `CWX_CYC_MUL;
            end
            `CWX_OP_NEXT: cyc_of = `CWX_CYC_NEXT;
            `CWX_OP_NOP:  cyc_of = `CWX_CYC_NOP;
            `CWX_OP_OR_W: cyc_of = `CWX_CYC_ORW;
            `CWX_OP_OR_WI, `CWX_OP_OR_R, `CWX_OP_OR_IR, `CWX_OP_OR_IM: begin
                cyc_of = `CWX_CYC_OR;
            end
            default: cyc_of = 5'h00;
        endcase
    endfunction : cyc_of

    cwx_apb u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .ctl     (ctl.bus)
    );

    // ======================================================================
    // Operand decode
    assign op      = cmd_reg[7:0];
    assign b1      = cmd_reg[15:8];
    assign b2      = cmd_reg[23:16];
    assign b3      = cmd_reg[31:24];
    assign is_or   = op >= `CWX_OP_OR_W && op <= `CWX_OP_OR_IM;
    assign is_mul  = op >= `CWX_OP_MUL_R && op <= `CWX_OP_MUL_IM;
    assign is_ldw  = op >= `CWX_OP_LDW_RR && op <= `CWX_OP_LDW_IM;
    assign busy    = state_reg != cwx_pkg::CWX_IDLE;
    assign run     = ce && state_reg == cwx_pkg::CWX_RUN;
    assign new_cyc = cyc_of(ctl.wdata[7:0]);
    assign start   = ce && ctl.wr_cmd && !busy && new_cyc != 5'h00;

    always_comb begin
        sa  = b1;
        da  = b2;
        imm = 1'b0;
        ind = 1'b0;
        case (op)
            `CWX_OP_OR_W, `CWX_OP_OR_WI: begin
                sa  = {`CWX_WORK_HI, b1[3:0]};
                da  = {`CWX_WORK_HI, b1[7:4]};
                ind = op == `CWX_OP_OR_WI;
            end
            `CWX_OP_OR_IR, `CWX_OP_MUL_IR, `CWX_OP_LDW_IR: ind = 1'b1;
            `CWX_OP_OR_IM, `CWX_OP_LDW_IM: begin
                da  = b1;
                imm = 1'b1;
            end
            `CWX_OP_MUL_IM: imm = 1'b1;
            default: ;
        endcase
        ea   = ind ? rf[sa] : sa;
        ep   = {ea[7:1], 1'b0};
        dp   = {da[7:1], 1'b0};
        src8 = imm ? ((op == `CWX_OP_OR_IM) ? b2 : b1) : rf[ea];
        srcw = imm ? {b2, b3} : {rf[ep], rf[{ep[7:1], 1'b1}]};
    end

    cwx_alu u_alu (
        .mul  (is_mul),
        .a    (is_mul ? rf[dp] : rf[da]),
        .b    (src8),
        .fin  (flags_reg),
        .res  (res),
        .fout (flags_next)
    );

    // ======================================================================
    // Register file: an instruction writes only its destination byte or pair,
    // so a source stays intact unless it shares an address with the destination.
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (ctl.wr_rfdata && !busy) begin
                rf[rfaddr_reg] <= ctl.wdata[7:0];
            end else if (run && is_or) begin
                rf[da] <= res[7:0];
            end else if (run && is_mul) begin
                rf[dp]               <= res[15:8];
                rf[{dp[7:1], 1'b1}]  <= res[7:0];
            end else if (run && is_ldw) begin
                rf[dp]               <= srcw[15:8];
                rf[{dp[7:1], 1'b1}]  <= srcw[7:0];
            end
        end
    end

    // ======================================================================
    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= cwx_pkg::CWX_IDLE;
            cmd_reg   <= 32'h0000_0000;
            cnt_reg   <= 5'h00;
            cyc_reg   <= 5'h00;
        end else if (ce) begin
            case (state_reg)
                cwx_pkg::CWX_IDLE: begin
                    if (start) begin
                        cmd_reg   <= ctl.wdata;
                        cyc_reg   <= new_cyc;
                        cnt_reg   <= new_cyc - 5'h01;
                        state_reg <= cwx_pkg::CWX_RUN;
                    end
                end
                cwx_pkg::CWX_RUN: begin
                    cnt_reg   <= cnt_reg - 5'h01;
                    state_reg <= (op == `CWX_OP_NEXT) ? cwx_pkg::CWX_FETCH
                                                      : cwx_pkg::CWX_HOLD;
                end
                cwx_pkg::CWX_FETCH: begin
                    if (cnt_reg != 5'h00) begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end
                    if (pm_valid) begin
                        state_reg <= (cnt_reg == 5'h00) ? cwx_pkg::CWX_IDLE
                                                        : cwx_pkg::CWX_HOLD;
                    end
                end
                cwx_pkg::CWX_HOLD: begin
                    if (cnt_reg == 5'h00) begin
                        state_reg <= cwx_pkg::CWX_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end
                end
                default: state_reg <= cwx_pkg::CWX_IDLE;
            endcase
        end
    end

    // An unknown opcode is refused and flagged; a new refusal wins over
    // a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg <= 1'b0;
        end else if (ce) begin
            if (ctl.wr_cmd && !busy && new_cyc == 5'h00) begin
                err_reg <= 1'b1;
            end else if (ctl.clr_err) begin
                err_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `CWX_FLAGS_RST;
        end else if (ce) begin
            if (run && (is_or || is_mul)) begin
                flags_reg <= flags_next;
            end else if (ctl.wr_flags && !busy) begin
                flags_reg <= ctl.wdata[7:0];
            end
        end
    end

    // ======================================================================
    // Threaded dispatch through the instruction pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg  <= `CWX_PC_RST;
            ip_reg  <= `CWX_IP_RST;
            pm_rd   <= 1'b0;
            pm_addr <= 16'h0000;
        end else if (ce) begin
            if (run && op == `CWX_OP_NEXT) begin
                pm_rd   <= 1'b1;
                pm_addr <= ip_reg;
            end else if (state_reg == cwx_pkg::CWX_FETCH && pm_valid) begin
                pm_rd  <= 1'b0;
                pc_reg <= pm_rdata;
                ip_reg <= ip_reg + `CWX_IP_STEP;
            end else if (!busy) begin
                if (ctl.wr_pc) begin
                    pc_reg <= ctl.wdata[15:0];
                end
                if (ctl.wr_ip) begin
                    ip_reg <= ctl.wdata[15:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfaddr_reg <= 8'h00;
        end else if (ce && ctl.wr_rfaddr) begin
            rfaddr_reg <= ctl.wdata[7:0];
        end
    end

    assign ctl.cmd    = cmd_reg;
    assign ctl.busy   = busy;
    assign ctl.err    = err_reg;
    assign ctl.flags  = flags_reg;
    assign ctl.pc     = pc_reg;
    assign ctl.ip     = ip_reg;
    assign ctl.rfaddr = rfaddr_reg;
    assign ctl.rfdata = rf[rfaddr_reg];

    // ======================================================================
    // Checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_len <= 5'h00;
        end else if (ce) begin
            run_len <= busy ? run_len + 5'h01 : 5'h00;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cycle_count: assert property ($fell(busy) |-> run_len == cyc_reg)
        else $error("instruction time differs from its cycle count");
    a_nop_time: assert property (
        (start && ctl.wdata[7:0] == `CWX_OP_NOP && ce) ##1 ce[*4]
        |-> busy ##1 !busy)
        else $error("no-operation did not end after four cycles");
    a_mul_carry: assert property ((run && is_mul) |=>
        flags_reg[`CWX_FLAG_C] == ($past(res) > 16'h00FF))
        else $error("multiply carry wrong");
    a_mul_zs: assert property ((run && is_mul) |=>
        flags_reg[`CWX_FLAG_Z] == ($past(res) == 16'h0000)
        && flags_reg[`CWX_FLAG_S] == $past(res[15])
        && !flags_reg[`CWX_FLAG_V]
        && flags_reg[3:0] == $past(flags_reg[3:0]))
        else $error("multiply zero, sign or overflow wrong");
    a_mul_pair: assert property ((run && is_mul) |=>
        rf[$past(dp)] == $past(res[15:8])
        && rf[$past(dp) | 8'h01] == $past(res[7:0]))
        else $error("product not split across the pair");
    a_or_flags: assert property ((run && is_or) |=>
        rf[$past(da)] == ($past(src8) | $past(rf[da]))
        && flags_reg[`CWX_FLAG_C] == $past(flags_reg[`CWX_FLAG_C])
        && flags_reg[`CWX_FLAG_S] == rf[$past(da)][7]
        && !flags_reg[`CWX_FLAG_V])
        else $error("OR result or flags wrong");
    a_flags_kept: assert property (
        (run && !is_or && !is_mul) |=> $stable(flags_reg))
        else $error("flags changed by a flag-neutral instruction");
    a_ldw_copy: assert property ((run && is_ldw) |=>
        {rf[$past(dp)], rf[$past(dp) | 8'h01]} == $past(srcw))
        else $error("word load copied wrong value");
    a_next_ip: assert property (
        (ce && state_reg == cwx_pkg::CWX_FETCH && pm_valid) |=>
        pc_reg == $past(pm_rdata) && ip_reg == $past(ip_reg) + 16'h0002)
        else $error("dispatch did not load counter or step pointer");

    c_mul: cover property (run && is_mul);
    c_next: cover property (ce && state_reg == cwx_pkg::CWX_FETCH
                            && pm_valid);
    c_or_w: cover property (run && op == `CWX_OP_OR_W);
    c_ldw_im: cover property (run && op == `CWX_OP_LDW_IM);
endmodule : cwx_exec

/* sim/cwx_pm_model.sv */
// Program-memory model that answers dispatch fetches.
`timescale 1ns/1ps
module cwx_pm_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pm_rd,
    input  wire logic [15:0] pm_addr,
    input  wire logic [3:0]  lat,
    output logic             pm_valid,
    output logic      [15:0] pm_rdata
);
    // ====================================================================
    // Fetch answer
    logic [3:0] wait_reg;
    // Between answers the data lines toggle, so a sample an odd number of cycles late never passes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 4'h0;
            pm_valid <= 1'b0;
            pm_rdata <= 16'h0000;
        end else if (pm_rd && !pm_valid && wait_reg == lat) begin
            wait_reg <= 4'h0;
            pm_valid <= 1'b1;
            pm_rdata <= pm_addr ^ 16'h5A3C;
        end else begin
            wait_reg <= (pm_rd && !pm_valid) ? wait_reg + 4'h1 : 4'h0;
            pm_valid <= 1'b0;
            pm_rdata <= ~pm_rdata;
        end
    end
endmodule : cwx_pm_model

/* sim/testbench.sv */
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
`include "cwx_defs.svh"
module testbench;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pm_rd;
    logic [15:0] pm_addr;
    logic [15:0] pm_rdata;
    logic        pm_valid;
    logic [3:0]  lat;
    logic [31:0] rd;
    logic        err_seen;
    int          cyc = 0;
    int          n_fail;
    int          checks_done;

    cwx_exec cwx_exec_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .pm_valid(pm_valid));
    cwx_pm_model cwx_pm_model_inst (.pclk(pclk), .presetn(presetn),
        .pm_rd(pm_rd), .pm_addr(pm_addr), .lat(lat),
        .pm_valid(pm_valid), .pm_rdata(pm_rdata));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    // ====================================================================
    // Reporting
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic cmp(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask : cmp

    task automatic cmp_rng(input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("FAIL cycles expected %0d..%0d seen %0d", lo, hi, g);
        end
    endtask : cmp_rng

    // ====================================================================
    // Bus cycles; an idle cycle follows each transfer.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rf_set(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, `CWX_OFS_RFADDR, {24'h0, a});
        apb(1'b1, `CWX_OFS_RFDATA, {24'h0, v});
    endtask : rf_set

    task automatic rf_chk(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, `CWX_OFS_RFADDR, {24'h0, a});
        apb(1'b0, `CWX_OFS_RFDATA, 32'h0);
        cmp("rf byte", {24'h0, v}, rd & 32'h0000_00FF);
    endtask : rf_chk

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        cmp("register", v, rd & 32'h0000_FFFF);
    endtask : reg_chk

    // Runs one instruction, then checks its time, one byte and the flags.
    task automatic op(input logic [31:0] c, input int n,
                      input logic [7:0] f, input logic [7:0] a,
                      input logic [7:0] v, input logic [7:0] fe);
        int t0;
        int i;
        apb(1'b1, `CWX_OFS_FLAGS, {24'h0, f});
        apb(1'b1, `CWX_OFS_CMD, c);
        t0 = cyc;
        i = 0;
        do begin
            apb(1'b0, `CWX_OFS_STATUS, 32'h0);
            i++;
        end while (rd[`CWX_ST_BUSY] !== 1'b0 && i < 40);
        if (rd[`CWX_ST_BUSY] !== 1'b0) begin
            n_fail++;
            conclude();
        end
        if (n > 0) cmp_rng(n - 1, n + 5, cyc - t0);
        rf_chk(a, v);
        reg_chk(`CWX_OFS_FLAGS, {24'h0, fe});
    endtask : op

    // ====================================================================
    // Scenarios
    task automatic sc_bus;
        reg_chk(`CWX_OFS_FLAGS, 32'h0);
        reg_chk(`CWX_OFS_PC, 32'h0);
        reg_chk(`CWX_OFS_IP, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        cmp("slverr", 32'h1, {31'h0, err_seen});
        apb(1'b1, `CWX_OFS_CMD, 32'h0000_0001);
        reg_chk(`CWX_OFS_STATUS, 32'h2);
        apb(1'b1, `CWX_OFS_STATUS, 32'h2);
        reg_chk(`CWX_OFS_STATUS, 32'h0);
    endtask : sc_bus

    task automatic sc_mul;
        rf_set(8'h10, 8'h20);
        rf_set(8'h12, 8'h09);
        op(32'h0010_1284, 22, 8'h1C, 8'h10, 8'h01, 8'h8C);
        rf_chk(8'h11, 8'h20);
        rf_set(8'h10, 8'hFF);
        op(32'h0010_0086, 22, 8'h1C, 8'h11, 8'h00, 8'h4C);
        rf_set(8'h10, 8'hFF);
        rf_set(8'h20, 8'h30);
        rf_set(8'h30, 8'hFF);
        op(32'h0010_2085, 22, 8'h1C, 8'h10, 8'hFE, 8'hAC);
        rf_chk(8'h11, 8'h01);
    endtask : sc_mul

    task automatic sc_or;
        rf_set(8'hC0, 8'h15);
        rf_set(8'hC1, 8'h2A);
        op(32'h0000_0142, 4, 8'h9C, 8'hC0, 8'h3F, 8'h8C);
        rf_chk(8'hC1, 8'h2A);
        rf_set(8'hC0, 8'h00);
        rf_set(8'hC2, 8'h40);
        rf_set(8'h40, 8'h80);
        op(32'h0000_0243, 6, 8'h9C, 8'hC0, 8'h80, 8'hAC);
        rf_set(8'h50, 8'h00);
        rf_set(8'h51, 8'h00);
        op(32'h0050_5144, 6, 8'h1C, 8'h50, 8'h00, 8'h4C);
        rf_set(8'h52, 8'h53);
        rf_set(8'h53, 8'h0F);
        rf_set(8'h54, 8'hF0);
        op(32'h0054_5245, 6, 8'h9C, 8'h54, 8'hFF, 8'hAC);
        rf_chk(8'h53, 8'h0F);
        rf_set(8'h55, 8'h02);
        op(32'h0008_5546, 6, 8'h9C, 8'h55, 8'h0A, 8'h8C);
    endtask : sc_or

    task automatic sc_ldw;
        rf_set(8'h04, 8'h06);
        rf_set(8'h05, 8'h1C);
        op(32'h0006_05C4, 8, 8'hFC, 8'h06, 8'h06, 8'hFC);
        rf_chk(8'h07, 8'h1C);
        rf_chk(8'h04, 8'h06);
        rf_set(8'h60, 8'h62);
        rf_set(8'h62, 8'h03);
        rf_set(8'h63, 8'h0F);
        op(32'h0008_60C5, 8, 8'h54, 8'h08, 8'h03, 8'h54);
        rf_chk(8'h09, 8'h0F);
        op(32'hEFBE_0AC6, 8, 8'hFC, 8'h0A, 8'hBE, 8'hFC);
        rf_chk(8'h0B, 8'hEF);
    endtask : sc_ldw

    task automatic sc_next;
        rf_set(8'h70, 8'h33);
        apb(1'b1, `CWX_OFS_IP, 32'h0100);
        op(32'h0000_000F, 10, 8'h28, 8'h70, 8'h33, 8'h28);
        reg_chk(`CWX_OFS_PC, 32'h5B3C);
        reg_chk(`CWX_OFS_IP, 32'h0102);
        lat <= 4'h7;
        op(32'h0000_000F, 10, 8'hA8, 8'h70, 8'h33, 8'hA8);
        reg_chk(`CWX_OFS_PC, 32'h5B3E);
        reg_chk(`CWX_OFS_IP, 32'h0104);
    endtask : sc_next

    task automatic sc_nop;
        apb(1'b1, `CWX_OFS_PC, 32'h1234);
        op(32'h0000_00FF, 4, 8'h54, 8'h70, 8'h33, 8'h54);
        reg_chk(`CWX_OFS_PC, 32'h1234);
        reg_chk(`CWX_OFS_IP, 32'h0104);
    endtask : sc_nop

    // A low clock enable must hold a running no-operation where it is.
    task automatic sc_ce;
        apb(1'b1, `CWX_OFS_CMD, 32'h0000_00FF);
        ce <= 1'b0;
        repeat (8) @(posedge pclk);
        ce <= 1'b1;
        reg_chk(`CWX_OFS_STATUS, 32'h1);
        reg_chk(`CWX_OFS_STATUS, 32'h0);
    endtask : sc_ce

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lat = 4'h1;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        sc_bus();
        sc_mul();
        sc_or();
        sc_ldw();
        sc_next();
        sc_nop();
        sc_ce();
        conclude();
    end
endmodule : testbench
